// ---- src/ncd_cic.sv ----
`timescale 1ns/1ns
module ncd_cic
    import ncd_pkg::*;
#(
    parameter int ORDER = 2,
    parameter int IW = 16,
    parameter int OW = 18,
    parameter int RW = 6,
    parameter int SW = 5,
    parameter int MAXR = 16,
    parameter int GW = IW + ORDER * $clog2(MAXR)
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_restart,
    input wire logic i_valid,
    input wire logic [IW-1:0] i_data,
    input wire logic [RW-1:0] i_ratio,
    input wire logic [SW-1:0] i_shift,
    output logic o_valid,
    output logic [OW-1:0] o_data
);
    // Refuse widths that cannot hold the ratio or the result
    if (MAXR >= (1 << RW) || OW > GW || ORDER < 1) begin : g_bad
        $error("ncd_cic: parameter set not supported");
    end

    logic signed [GW-1:0] integ_q [ORDER];
    logic signed [GW-1:0] integ_d [ORDER];
    logic signed [GW-1:0] dly_q [ORDER];
    logic signed [GW-1:0] dly_d [ORDER];
    logic [RW-1:0] cnt_q, cnt_d;
    logic valid_q, valid_d;
    logic [OW-1:0] data_q, data_d;

    // Integrators at input rate, combs at output rate; wrap-around is harmless
    always_comb begin
        logic signed [GW-1:0] acc;
        logic signed [GW-1:0] shf;
        acc = '0;
        shf = '0;
        integ_d = integ_q;
        dly_d = dly_q;
        cnt_d = cnt_q;
        valid_d = 1'b0;
        data_d = data_q;
        if (i_valid) begin
            acc = {{(GW-IW){i_data[IW-1]}}, i_data};
            for (int k = 0; k < ORDER; k++) begin
                acc = integ_q[k] + acc;
                integ_d[k] = acc;
            end
            if ({1'b0, cnt_q} + 1'b1 >= {1'b0, i_ratio}) begin
                cnt_d = '0;
                for (int k = 0; k < ORDER; k++) begin
                    dly_d[k] = acc;
                    acc = acc - dly_q[k];
                end
                shf = acc >>> i_shift;
                valid_d = 1'b1;
                data_d = shf[OW-1:0];
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        if (i_restart) begin
            cnt_d = '0;
        end
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int k = 0; k < ORDER; k++) begin
                integ_q[k] <= '0;
                dly_q[k] <= '0;
            end
            cnt_q <= '0;
            valid_q <= 1'b0;
            data_q <= '0;
        end else begin
            integ_q <= integ_d;
            dly_q <= dly_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
            data_q <= data_d;
        end
    end

    assign o_valid = valid_q;
    assign o_data = data_q;

endmodule : ncd_cic

// ---- src/ncd_pkg.sv ----
package ncd_pkg;

    // Register byte addresses
    localparam logic [11:0] NCD_ADDR_CTRL = 12'h000;
    localparam logic [11:0] NCD_ADDR_TUNE = 12'h004;
    localparam logic [11:0] NCD_ADDR_STAGE2 = 12'h008;
    localparam logic [11:0] NCD_ADDR_STAGE5 = 12'h00c;
    localparam logic [11:0] NCD_ADDR_PHASE = 12'h010;

    // Field positions
    localparam int NCD_CTRL_MASTER_BIT = 0;
    localparam int NCD_CTRL_MODE_LSB = 1;
    localparam int NCD_RATIO_LSB = 0;
    localparam int NCD_ATTEN_LSB = 8;

    // Field limits and scaling offsets
    localparam logic [5:0] NCD_RATIO_MIN = 6'h01;
    localparam logic [5:0] NCD_S2_RATIO_MAX = 6'h10;
    localparam logic [5:0] NCD_S5_RATIO_MAX = 6'h20;
    localparam logic [5:0] NCD_ATTEN_MIN = 6'h00;
    localparam logic [5:0] NCD_S2_ATTEN_MAX = 6'h06;
    localparam logic [5:0] NCD_S5_ATTEN_MAX = 6'h14;
    localparam logic [4:0] NCD_S2_SHIFT_BASE = 5'h02;
    localparam logic [4:0] NCD_S5_SHIFT_BASE = 5'h05;

    // Reset values
    localparam logic NCD_RST_MASTER = 1'b1;
    localparam logic [31:0] NCD_RST_TUNE = 32'h0000_0000;
    localparam logic [5:0] NCD_RST_RATIO = 6'h01;
    localparam logic [5:0] NCD_RST_ATTEN = 6'h00;

    // Data widths
    localparam int NCD_IN_W = 16;
    localparam int NCD_S2_OUT_W = 18;
    localparam int NCD_S5_OUT_W = 20;

    // Input modes, Gray coded
    typedef enum logic [1:0] {
        NCD_MODE_REAL = 2'b00,
        NCD_MODE_COMPLEX = 2'b01,
        NCD_MODE_DIVERSITY = 2'b11
    } ncd_mode_t;

    // Shared I/Q path word
    typedef struct packed {
        logic valid;
        logic is_q;
        logic [NCD_S2_OUT_W-1:0] data;
    } ncd_mid_t;

    // Fifth-order output word
    typedef struct packed {
        logic valid;
        logic is_q;
        logic [NCD_S5_OUT_W-1:0] data;
    } ncd_out_t;

endpackage : ncd_pkg

// ---- src/ncd_top.sv ----
`timescale 1ns/1ns
module ncd_top
    import ncd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_ab_sel,
    input wire logic i_sync_in,
    output logic o_sync_out,
    output logic o_sync_oe,
    input wire logic i_mix_valid,
    input wire logic [NCD_IN_W-1:0] i_mix_i,
    input wire logic [NCD_IN_W-1:0] i_mix_q,
    output logic [31:0] o_osc_phase,
    output logic o_out_valid,
    output logic o_out_is_q,
    output logic [NCD_S5_OUT_W-1:0] o_out_data
);
    // Clamp a written field into its legal range
    function automatic logic [5:0] ncd_clamp(input logic [5:0] v, input logic [5:0] lo, input logic [5:0] hi);
        logic [5:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : ncd_clamp

    // ---- Register file state
    logic master_q, master_d;
    ncd_mode_t mode_q, mode_d;
    logic [31:0] tune_q, tune_d;
    logic [5:0] s2_ratio_q, s2_ratio_d, s2_atten_q, s2_atten_d;
    logic [5:0] s5_ratio_q, s5_ratio_d, s5_atten_q, s5_atten_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic accept, wr_s2, wr_s5, tune_access;

    // Access completes at the second access-phase edge
    assign accept = i_psel & i_penable & pready_q;
    assign tune_access = accept & (i_paddr == NCD_ADDR_TUNE);
    assign wr_s2 = accept & i_pwrite & (i_paddr == NCD_ADDR_STAGE2);
    assign wr_s5 = accept & i_pwrite & (i_paddr == NCD_ADDR_STAGE5);

    // APB decode, write and read data
    always_comb begin
        logic mapped;
        mapped = (i_paddr == NCD_ADDR_CTRL) || (i_paddr == NCD_ADDR_TUNE) || (i_paddr == NCD_ADDR_STAGE2)
            || (i_paddr == NCD_ADDR_STAGE5) || (i_paddr == NCD_ADDR_PHASE);
        master_d = master_q;
        mode_d = mode_q;
        tune_d = tune_q;
        s2_ratio_d = s2_ratio_q;
        s2_atten_d = s2_atten_q;
        s5_ratio_d = s5_ratio_q;
        s5_atten_d = s5_atten_q;
        pready_d = i_psel & i_penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (pready_d) begin
            pslverr_d = ~mapped;
            case (i_paddr)
                NCD_ADDR_CTRL: prdata_d = {29'h0, mode_q, master_q};
                NCD_ADDR_TUNE: prdata_d = tune_q;
                NCD_ADDR_STAGE2: prdata_d = {18'h0, s2_atten_q, 2'h0, s2_ratio_q};
                NCD_ADDR_STAGE5: prdata_d = {18'h0, s5_atten_q, 2'h0, s5_ratio_q};
                NCD_ADDR_PHASE: prdata_d = o_osc_phase;
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        if (accept && i_pwrite) begin
            case (i_paddr)
                NCD_ADDR_CTRL: begin
                    master_d = i_pwdata[NCD_CTRL_MASTER_BIT];
                    mode_d = ncd_mode_t'(i_pwdata[NCD_CTRL_MODE_LSB +: 2]);
                end
                NCD_ADDR_TUNE: tune_d = i_pwdata;
                NCD_ADDR_STAGE2: begin
                    s2_ratio_d = ncd_clamp(i_pwdata[NCD_RATIO_LSB +: 6], NCD_RATIO_MIN, NCD_S2_RATIO_MAX);
                    s2_atten_d = ncd_clamp(i_pwdata[NCD_ATTEN_LSB +: 6], NCD_ATTEN_MIN, NCD_S2_ATTEN_MAX);
                end
                NCD_ADDR_STAGE5: begin
                    s5_ratio_d = ncd_clamp(i_pwdata[NCD_RATIO_LSB +: 6], NCD_RATIO_MIN, NCD_S5_RATIO_MAX);
                    s5_atten_d = ncd_clamp(i_pwdata[NCD_ATTEN_LSB +: 6], NCD_ATTEN_MIN, NCD_S5_ATTEN_MAX);
                end
                default: ;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            master_q <= NCD_RST_MASTER;
            mode_q <= NCD_MODE_REAL;
            tune_q <= NCD_RST_TUNE;
            s2_ratio_q <= NCD_RST_RATIO;
            s2_atten_q <= NCD_RST_ATTEN;
            s5_ratio_q <= NCD_RST_RATIO;
            s5_atten_q <= NCD_RST_ATTEN;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            master_q <= master_d;
            mode_q <= mode_d;
            tune_q <= tune_d;
            s2_ratio_q <= s2_ratio_d;
            s2_atten_q <= s2_atten_d;
            s5_ratio_q <= s5_ratio_d;
            s5_atten_q <= s5_atten_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_prdata = prdata_q;

    // ---- Pin synchronisers; first stage feeds only the second
    logic ab_meta_q, ab_q, ab_prev_q, sync_meta_q, sync_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ab_meta_q <= 1'b0;
            ab_q <= 1'b0;
            ab_prev_q <= 1'b0;
            sync_meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            ab_meta_q <= i_ab_sel;
            ab_q <= ab_meta_q;
            ab_prev_q <= ab_q;
            sync_meta_q <= i_sync_in;
            sync_q <= sync_meta_q;
        end
    end

    // ---- Oscillator phase and sync
    logic [31:0] phase_q, phase_d;
    logic master_prev_q, rearm_q, rearm_d, sync_out_q, sync_out_d;
    logic advance, wrap, int_sync;
    logic [32:0] phase_sum;

    // Real mode: select level steps the phase; other modes: select toggles
    always_comb begin
        case (mode_q)
            NCD_MODE_REAL: advance = ab_q;
            NCD_MODE_COMPLEX: advance = ab_q ^ ab_prev_q;
            NCD_MODE_DIVERSITY: advance = ab_q ^ ab_prev_q;
            default: advance = ab_q;
        endcase
    end

    assign phase_sum = {1'b0, phase_q} + {1'b0, tune_q};
    assign wrap = advance & phase_sum[32];

    always_comb begin
        // tuning access syncs only as master
        int_sync = master_q & tune_access;
        rearm_d = rearm_q;
        // rearm on slave to master, fire at zero crossing
        if (master_q && rearm_q && wrap) begin
            int_sync = 1'b1;
            rearm_d = 1'b0;
        end
        if (master_q && !master_prev_q) begin
            rearm_d = 1'b1;
        end
        if (!master_q) begin
            rearm_d = 1'b0;
        end
        // master pulses pin, slave holds phase at zero while pin high
        sync_out_d = int_sync;
        if (int_sync || (!master_q && sync_q)) begin
            phase_d = 32'h0000_0000;
        end else if (advance) begin
            phase_d = phase_sum[31:0];
        end else begin
            phase_d = phase_q;
        end
    end

    // Oscillator flops
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_q <= 32'h0000_0000;
            master_prev_q <= NCD_RST_MASTER;
            rearm_q <= 1'b0;
            sync_out_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            master_prev_q <= master_q;
            rearm_q <= rearm_d;
            sync_out_q <= sync_out_d;
        end
    end

    assign o_osc_phase = phase_q;
    assign o_sync_out = sync_out_q;
    assign o_sync_oe = master_q;

    // ---- Second-order stage, I and Q in parallel
    logic s2i_valid, s2q_valid;
    logic [NCD_S2_OUT_W-1:0] s2i_data, s2q_data;
    logic [4:0] s2_shift, s5_shift;
    // shift by atten+2 even at ratio 1
    assign s2_shift = s2_atten_q[4:0] + NCD_S2_SHIFT_BASE;
    assign s5_shift = s5_atten_q[4:0] + NCD_S5_SHIFT_BASE;

    // one sample per clock, parallel I/Q
    ncd_cic #(.ORDER(2), .IW(NCD_IN_W), .OW(NCD_S2_OUT_W), .RW(6), .SW(5), .MAXR(16)) u_s2_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_restart(wr_s2), .i_valid(i_mix_valid), .i_data(i_mix_i),
        .i_ratio(s2_ratio_q), .i_shift(s2_shift), .o_valid(s2i_valid), .o_data(s2i_data)
    );
    ncd_cic #(.ORDER(2), .IW(NCD_IN_W), .OW(NCD_S2_OUT_W), .RW(6), .SW(5), .MAXR(16)) u_s2_q (
        .i_clk(i_clk), .i_reset(i_reset), .i_restart(wr_s2), .i_valid(i_mix_valid), .i_data(i_mix_q),
        .i_ratio(s2_ratio_q), .i_shift(s2_shift), .o_valid(s2q_valid), .o_data(s2q_data)
    );

    // ---- Shared path: I then Q on consecutive cycles
    ncd_mid_t mid_q, mid_d;
    logic q_pend_q, q_pend_d;
    logic [NCD_S2_OUT_W-1:0] q_hold_q, q_hold_d;
    always_comb begin
        mid_d = '0;
        q_pend_d = q_pend_q;
        q_hold_d = q_hold_q;
        if (s2i_valid) begin
            mid_d = '{valid: 1'b1, is_q: 1'b0, data: s2i_data};
            q_hold_d = s2q_data;
            q_pend_d = 1'b1;
        end else if (q_pend_q) begin
            mid_d = '{valid: 1'b1, is_q: 1'b1, data: q_hold_q};
            q_pend_d = 1'b0;
        end
    end

    // Shared path flops; a Q still waiting would be lost if the rate limits are broken
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mid_q <= '0;
            q_pend_q <= 1'b0;
            q_hold_q <= '0;
        end else begin
            mid_q <= mid_d;
            q_pend_q <= q_pend_d;
            q_hold_q <= q_hold_d;
        end
    end

    // ---- Fifth-order stage, one filter state per channel
    logic s5i_valid, s5q_valid;
    logic [NCD_S5_OUT_W-1:0] s5i_data, s5q_data;
    ncd_cic #(.ORDER(5), .IW(NCD_S2_OUT_W), .OW(NCD_S5_OUT_W), .RW(6), .SW(5), .MAXR(32)) u_s5_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_restart(wr_s5), .i_valid(mid_q.valid & ~mid_q.is_q),
        .i_data(mid_q.data), .i_ratio(s5_ratio_q), .i_shift(s5_shift), .o_valid(s5i_valid), .o_data(s5i_data)
    );
    ncd_cic #(.ORDER(5), .IW(NCD_S2_OUT_W), .OW(NCD_S5_OUT_W), .RW(6), .SW(5), .MAXR(32)) u_s5_q (
        .i_clk(i_clk), .i_reset(i_reset), .i_restart(wr_s5), .i_valid(mid_q.valid & mid_q.is_q),
        .i_data(mid_q.data), .i_ratio(s5_ratio_q), .i_shift(s5_shift), .o_valid(s5q_valid), .o_data(s5q_data)
    );

    // ---- Output stage
    ncd_out_t out_q, out_d;
    always_comb begin
        out_d = '0;
        if (s5_ratio_q == NCD_RATIO_MIN) begin
            out_d.valid = mid_q.valid;
            out_d.is_q = mid_q.is_q;
            out_d.data = {{(NCD_S5_OUT_W-NCD_S2_OUT_W){mid_q.data[NCD_S2_OUT_W-1]}}, mid_q.data};
        end else if (s5i_valid) begin
            out_d = '{valid: 1'b1, is_q: 1'b0, data: s5i_data};
        end else if (s5q_valid) begin
            out_d = '{valid: 1'b1, is_q: 1'b1, data: s5q_data};
        end
    end

    // Output flops
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign o_out_valid = out_q.valid;
    assign o_out_is_q = out_q.is_q;
    assign o_out_data = out_q.data;

    // ---- Checking helpers: inputs seen since last second-order output
    logic [5:0] chk_q, chk_d;
    always_comb begin
        chk_d = chk_q;
        if (s2i_valid) begin
            chk_d = {5'h00, i_mix_valid};
        end else if (i_mix_valid) begin
            chk_d = chk_q + 6'h01;
        end
        if (wr_s2) begin
            chk_d = 6'h00;
        end
    end

    // Helper flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            chk_q <= 6'h00;
        end else begin
            chk_q <= chk_d;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_phase_advance: assert property (
        (mode_q == NCD_MODE_REAL && ab_q && !int_sync && (master_q || !sync_q))
        |=> o_osc_phase == $past(phase_q) + $past(tune_q)
    ) else $error("phase did not advance by tuning word");

    a_phase_hold: assert property (
        (mode_q == NCD_MODE_REAL && !ab_q && !int_sync && (master_q || !sync_q)) |=> $stable(o_osc_phase)
    ) else $error("phase moved without select");

    a_master_tune_sync: assert property (
        (master_q && tune_access) |=> (o_osc_phase == 32'h0000_0000 && o_sync_out)
    ) else $error("tuning access as master gave no sync");

    a_slave_no_sync: assert property (
        (!master_q && tune_access && !sync_q) |=> !o_sync_out
    ) else $error("tuning write as slave made a sync");

    a_rearm_zero: assert property (
        (master_q && rearm_q && wrap) |=> (o_sync_out && o_osc_phase == 32'h0000_0000)
    ) else $error("rearmed sync missed zero crossing");

    a_stage2_count: assert property (
        $rose(s2i_valid) || (s2i_valid && $past(s2i_valid)) |-> chk_q == s2_ratio_q
    ) else $error("second stage output count wrong");

    a_serial_order: assert property (
        s2i_valid |=> (mid_q.valid && !mid_q.is_q) ##1 (mid_q.valid && mid_q.is_q)
    ) else $error("I/Q order on shared path wrong");

    a_fifth_bypass: assert property (
        (s5_ratio_q == NCD_RATIO_MIN && $stable(s5_ratio_q) && mid_q.valid)
        |=> (o_out_valid && o_out_data[NCD_S2_OUT_W-1:0] == $past(mid_q.data))
    ) else $error("fifth stage bypass altered data");

    a_sync_pin_dir: assert property (
        o_sync_out |-> o_sync_oe
    ) else $error("sync pulse driven while slave");

    a_atten_range: assert property (
        s2_atten_q <= NCD_S2_ATTEN_MAX && s5_atten_q <= NCD_S5_ATTEN_MAX
    ) else $error("attenuation out of range");

    c_stage2_out: cover property (s2i_valid ##[1:2] mid_q.is_q);
    c_rearm_fire: cover property (master_q && rearm_q && wrap);
    c_slave_tune: cover property (!master_q && tune_access);
    c_fifth_out: cover property (o_out_valid && s5_ratio_q > NCD_RATIO_MIN);

endmodule : ncd_top

// ---- test/ncd_adc_model.sv ----
`timescale 1ns/1ns
module ncd_adc_model
    import ncd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_step,
    input wire logic i_send,
    input wire logic [NCD_IN_W-1:0] i_i,
    input wire logic [NCD_IN_W-1:0] i_q,
    output logic o_ab_sel = 1'b0,
    output logic o_mix_valid = 1'b0,
    output logic [NCD_IN_W-1:0] o_mix_i = 16'h0000,
    output logic [NCD_IN_W-1:0] o_mix_q = 16'h0000
);
    // Converter lines, all launched just after a rising edge
    // select copies i_step one clock late, so it stays high as long as i_step does
    always @(posedge i_clk) begin
        o_ab_sel <= i_step;
        o_mix_valid <= i_send;
        // Idle data toggles so a stale word never passes as a fresh one
        o_mix_i <= i_send ? i_i : ~o_mix_i;
        o_mix_q <= i_send ? i_q : ~o_mix_q;
    end
endmodule : ncd_adc_model

// ---- test/nco_tuning_and_cic_decimators_test.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module nco_tuning_and_cic_decimators_test
    import ncd_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sync_in = 1'b0, step = 1'b0, snd = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ab_sel, mix_valid, sync_out, sync_oe, out_valid, out_is_q;
    logic [15:0] mix_i, mix_q, ii = 16'h0000, qq = 16'h0000;
    logic [31:0] phase;
    logic [19:0] out_data, last_i, last_q;
    int err_count = 0, check_count = 0, syncs = 0, n_i = 0, cyc = 0, s0, n0;

    ncd_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ab_sel(ab_sel), .i_sync_in(sync_in), .o_sync_out(sync_out), .o_sync_oe(sync_oe),
        .i_mix_valid(mix_valid), .i_mix_i(mix_i), .i_mix_q(mix_q), .o_osc_phase(phase),
        .o_out_valid(out_valid), .o_out_is_q(out_is_q), .o_out_data(out_data));
    ncd_adc_model adc (.i_clk(i_clk), .i_step(step), .i_send(snd), .i_i(ii), .i_q(qq),
        .o_ab_sel(ab_sel), .o_mix_valid(mix_valid), .o_mix_i(mix_i), .o_mix_q(mix_q));

    // 125 MHz clock
    initial begin
        forever #4 i_clk = ~i_clk;
    end

    // Output monitor and hang guard; the ceiling is far above the run length
    always @(posedge i_clk) begin
        cyc++;
        if (sync_out === 1'b1) syncs++;
        if (out_valid === 1'b1 && out_is_q === 1'b0) begin
            last_i <= out_data;
            n_i++;
        end
        if (out_valid === 1'b1 && out_is_q === 1'b1) last_q <= out_data;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // APB transfer: setup, access held until pready is seen high at a rising edge
    // No wait limit here; a hang is caught by the cycle ceiling
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK("read data", ex, rd)
    endtask : rd_chk

    // Select pulses spaced two clocks apart, then let the pin synchroniser settle
    task automatic steps(input int n);
        repeat (n) begin
            @(posedge i_clk) step <= 1'b1;
            @(posedge i_clk) step <= 1'b0;
        end
        repeat (6) @(posedge i_clk);
    endtask : steps

    task automatic send(input int n, input logic [15:0] vi, input logic [15:0] vq);
        @(posedge i_clk);
        snd <= 1'b1; ii <= vi; qq <= vq;
        repeat (n) @(posedge i_clk);
        snd <= 1'b0;
        repeat (24) @(posedge i_clk);
    endtask : send

    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        rd_chk(NCD_ADDR_CTRL, 32'h1);
        rd_chk(NCD_ADDR_TUNE, 32'h0);
        rd_chk(NCD_ADDR_STAGE2, 32'h1);
        rd_chk(NCD_ADDR_STAGE5, 32'h1);
        rd_chk(12'h020, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        // Master: tuning access forces a sync, select steps the phase
        s0 = syncs;
        apb(1'b1, NCD_ADDR_TUNE, 32'h100);
        repeat (3) @(posedge i_clk);
        `CHK("sync count", s0 + 1, syncs)
        steps(3);
        rd_chk(NCD_ADDR_PHASE, 32'h300);
        rd_chk(NCD_ADDR_TUNE, 32'h100);
        repeat (3) @(posedge i_clk);
        `CHK("phase after read", 32'h0, phase)
        // Slave: retune without sync, then external sync holds phase at zero
        apb(1'b1, NCD_ADDR_CTRL, 32'h0);
        steps(2);
        s0 = syncs;
        apb(1'b1, NCD_ADDR_TUNE, 32'h8000_0000);
        repeat (3) @(posedge i_clk);
        `CHK("slave phase", 32'h200, phase)
        `CHK("slave syncs", s0, syncs)
        `CHK("slave drive", 1'b0, sync_oe)
        @(posedge i_clk) sync_in <= 1'b1;
        repeat (6) @(posedge i_clk);
        sync_in <= 1'b0;
        `CHK("held phase", 32'h0, phase)
        // Back to master: sync on the next wrap only
        apb(1'b1, NCD_ADDR_CTRL, 32'h1);
        steps(1);
        `CHK("no wrap yet", s0, syncs)
        steps(1);
        `CHK("wrap sync", s0 + 1, syncs)
        `CHK("master drive", 1'b1, sync_oe)
        // Both stages at ratio 1, fifth stage bypassed; single samples keep the shared path within rate
        apb(1'b1, NCD_ADDR_STAGE5, 32'h1401);
        send(1, 16'h1000, 16'hf000);
        `CHK("bypass i", 20'h00400, last_i)
        `CHK("bypass q", 20'hffc00, last_q)
        apb(1'b1, NCD_ADDR_STAGE2, 32'h0201);
        send(1, 16'h1000, 16'hf000);
        `CHK("atten i", 20'h00100, last_i)
        `CHK("atten q", 20'hfff00, last_q)
        // Full-rate input, ratio 4 then 2: gain 16/16 and 32/32 gives unity
        apb(1'b1, NCD_ADDR_STAGE2, 32'h0204);
        apb(1'b1, NCD_ADDR_STAGE5, 32'h0002);
        n0 = n_i;
        send(64, 16'h1000, 16'hf000);
        `CHK("output count", n0 + 8, n_i)
        `CHK("decim i", 20'h01000, last_i)
        `CHK("decim q", 20'hff000, last_q)
        // Complex mode: each select toggle steps the phase, so one pulse steps twice
        apb(1'b1, NCD_ADDR_CTRL, 32'h3);
        apb(1'b1, NCD_ADDR_TUNE, 32'h100);
        steps(1);
        rd_chk(NCD_ADDR_PHASE, 32'h200);
        conclude();
    end
endmodule : nco_tuning_and_cic_decimators_test
